// ---- rtl/ietu_regs.svh ----
`ifndef IETU_REGS_SVH
`define IETU_REGS_SVH

// Register byte offsets
`define IETU_VBR_OFF 8'h00
`define IETU_SR_OFF 8'h04
`define IETU_VEC_OFF 8'h08
`define IETU_PC_OFF 8'h0C
`define IETU_PTR_OFF 8'h10
`define IETU_CNT_OFF 8'h14

// Reset values
`define IETU_VBR_RST 32'h0000_0000
`define IETU_SR_RST 16'h2700

// Status word fields
`define IETU_SR_T1 15
`define IETU_SR_T0 14
`define IETU_SR_S 13

// Vector numbers
`define IETU_VEC_ILLEGAL 8'h04
`define IETU_VEC_DIV0 8'h05
`define IETU_VEC_BOUND 8'h06
`define IETU_VEC_COND 8'h07
`define IETU_VEC_PRIV 8'h08
`define IETU_VEC_TRACE 8'h09
`define IETU_VEC_UNIMPL 8'h0A
`define IETU_VEC_TRAPBASE 8'h20

// Opcode line of unimplemented words
`define IETU_ALINE 4'hA

// Bus responses
`define IETU_RESP_OK 2'b00
`define IETU_RESP_ERR 2'b10

`endif

// ---- rtl/ietu_pkg.sv ----
package ietu_pkg;

  typedef enum logic [3:0] {
    C_NONE,
    C_ILLEGAL,
    C_UNIMPL,
    C_PRIV,
    C_DIV0,
    C_BOUND,
    C_COND,
    C_SWTRAP,
    C_TRACE
  } ietu_cause_t;

  typedef enum logic [1:0] {
    FK_DIV0,
    FK_BOUND,
    FK_COND,
    FK_SWTRAP
  } ietu_forced_t;

  typedef enum logic [1:0] {
    TM_NONE = 2'b00,
    TM_COF = 2'b01,
    TM_ALL = 2'b10,
    TM_RSVD = 2'b11
  } ietu_trace_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_TRACE = 2'b11
  } ietu_state_t;

endpackage

// ---- rtl/ietu_vec_sel.sv ----
`timescale 1ns/1ps
`include "ietu_regs.svh"

module ietu_vec_sel import ietu_pkg::*; (
  // Cause
  input ietu_cause_t cause,
  input logic [3:0] trap_num,
  // Vector
  output logic [7:0] vector,
  output logic [9:0] offset
);

  always_comb begin
    unique case (cause)
      C_ILLEGAL: vector = `IETU_VEC_ILLEGAL;
      C_UNIMPL: vector = `IETU_VEC_UNIMPL;
      C_PRIV: vector = `IETU_VEC_PRIV;
      C_DIV0: vector = `IETU_VEC_DIV0;
      C_BOUND: vector = `IETU_VEC_BOUND;
      C_COND: vector = `IETU_VEC_COND;
      C_SWTRAP: vector = `IETU_VEC_TRAPBASE + {4'h0, trap_num};
      C_TRACE: vector = `IETU_VEC_TRACE;
      default: vector = 8'h00;
    endcase
  end

  assign offset = {vector, 2'b00};

endmodule

// ---- rtl/ietu_axil.sv ----
`timescale 1ns/1ps
`include "ietu_regs.svh"

module ietu_axil #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // Write address
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // Write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // Read address
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // Read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Register side
  output logic reg_we,
  output logic [ADDR_W-1:0] reg_waddr,
  output logic [31:0] reg_wdata,
  output logic [3:0] reg_wstrb,
  input logic reg_werr,
  output logic [ADDR_W-1:0] reg_raddr,
  input logic [31:0] reg_rdata,
  input logic reg_rerr
);

  logic aw_full_r;
  logic w_full_r;

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign reg_we = ce && aw_full_r && w_full_r && !s_axi_bvalid;
  assign reg_raddr = s_axi_araddr;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      reg_waddr <= '0;
      reg_wdata <= 32'h0000_0000;
      reg_wstrb <= 4'h0;
    end else if (ce) begin
      if (reg_we) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          aw_full_r <= 1'b1;
          reg_waddr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          w_full_r <= 1'b1;
          reg_wdata <= s_axi_wdata;
          reg_wstrb <= s_axi_wstrb;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IETU_RESP_OK;
    end else if (ce) begin
      if (reg_we) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_werr ? `IETU_RESP_ERR : `IETU_RESP_OK;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IETU_RESP_OK;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= reg_rerr ? 32'h0000_0000 : reg_rdata;
        s_axi_rresp <= reg_rerr ? `IETU_RESP_ERR : `IETU_RESP_OK;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ---- rtl/ietu_core.sv ----
`timescale 1ns/1ps
`include "ietu_regs.svh"

// Behaviour
// - Vectors 5 divide, 6 bounds, 7 traps
// - Software trap vector is 32 plus n
// - Copy status, supervisor on, trace bits cleared
// - Trap stacks next pc, offset, status copy
// - Non-software traps also stack faulting pointer
// - Invalid opcode raises vector 4
// - Ended breakpoint cycle raises illegal instruction
// - Undefined control register specifier is illegal
// - Opcode line A raises vector 10
// - Illegal opcode not executed, stacks own address
// - User mode refuses privileged instructions
// - Privilege violation before execution, vector 8
// - Privilege violation stacks instruction first word
// - Trace bits: none, flow, all, reserved
// - Trace bits sampled at start, trap after
// - Flow mode traces only flow changes; the code also traces a stop
// - Trace: copy, supervisor, clear, vector 9
// - Suspended traced instruction defers its trace
// - Trace goes before pending interrupt
// - Forced exception first, then trace
// - Illegal opcodes never produce trace exception
// - Traced stop loads status, traces, never stops

module ietu_core import ietu_pkg::*; #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  input logic ce,
  // AXI4-Lite write address
  input logic [ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  // AXI4-Lite read address
  input logic [ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Instruction start
  input logic instr_start,
  input logic [31:0] instr_pc,
  input logic [15:0] opcode,
  input logic illegal_op,
  input logic creg_spec_undef,
  input logic priv_op,
  // Instruction completion
  input logic instr_done,
  input logic instr_suspend,
  input logic [31:0] instr_next_pc,
  input logic cof_op,
  input logic stop_op,
  input logic forced_exc,
  input ietu_forced_t forced_kind,
  input logic [3:0] trap_num,
  // Status word load
  input logic sr_load,
  input logic [15:0] sr_load_data,
  // Breakpoint acknowledge cycle
  input logic bkpt_cycle,
  input logic transfer_ack_n,
  input logic transfer_error_ack_n,
  // Interrupt gate
  input logic irq_pending,
  output logic irq_take,
  // Exception output
  output logic exc_valid,
  output logic [7:0] exc_vector,
  output logic [9:0] exc_offset,
  output logic [31:0] exc_handler_addr,
  output logic [31:0] exc_stack_pc,
  output logic [31:0] exc_fault_ptr,
  output logic exc_fault_ptr_valid,
  output logic [15:0] exc_saved_sr,
  output logic [15:0] status_word,
  output logic stop_enter
);

  ietu_state_t st_r;
  ietu_state_t st_nxt;
  ietu_trace_t mode_r;
  logic [31:0] pc_r;
  logic [31:0] npc_r;
  logic [31:0] vbr_r;
  logic [31:0] cnt_r;
  logic [15:0] sr_cur;
  ietu_cause_t cause;
  logic [31:0] stack_pc;
  logic fault_ptr_ok;
  logic done_eff;
  logic bkpt_end;
  logic traced;
  logic take;
  logic [7:0] vec;
  logic [9:0] off;
  logic reg_we;
  logic [ADDR_W-1:0] reg_waddr;
  logic [31:0] reg_wdata;
  logic [3:0] reg_wstrb;
  logic reg_werr;
  logic [ADDR_W-1:0] reg_raddr;
  logic [31:0] reg_rdata;
  logic reg_rerr;

  // Decode trace mode; reserved traces nothing
  function automatic logic trace_hit(input ietu_trace_t m, input logic flow);
    trace_hit = (m == TM_ALL) || ((m == TM_COF) && flow);
  endfunction

  function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
    strb_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        strb_merge[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
  endfunction

  ietu_axil #(
    .ADDR_W(ADDR_W)
  ) u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .reg_we(reg_we),
    .reg_waddr(reg_waddr),
    .reg_wdata(reg_wdata),
    .reg_wstrb(reg_wstrb),
    .reg_werr(reg_werr),
    .reg_raddr(reg_raddr),
    .reg_rdata(reg_rdata),
    .reg_rerr(reg_rerr)
  );

  ietu_vec_sel u_vec (
    .cause(cause),
    .trap_num(trap_num),
    .vector(vec),
    .offset(off)
  );

  // Completion while suspended is not a completion
  // Trace waits for resumed completion
  assign done_eff = instr_done && !instr_suspend && (st_r == ST_EXEC);

  assign bkpt_end = bkpt_cycle && (!transfer_ack_n || !transfer_error_ack_n);

  // Mode held from start of instruction
  // Flow mode needs a flow change or a stop
  assign traced = trace_hit(mode_r, cof_op || stop_op);

  // A status load in the completing cycle is what gets saved
  // Stop's loaded status word is copied
  assign sr_cur = sr_load ? sr_load_data : status_word;

  // Cause priority: pending trace, breakpoint end, start checks, completion
  always_comb begin
    cause = C_NONE;
    stack_pc = pc_r;
    fault_ptr_ok = 1'b0;
    if (st_r == ST_TRACE) begin
      cause = C_TRACE;
      stack_pc = npc_r;
    end else if (bkpt_end) begin
      cause = C_ILLEGAL;
      stack_pc = pc_r;
    end else if (instr_start) begin
      stack_pc = instr_pc;
      if (opcode[15:12] == `IETU_ALINE) begin
        cause = C_UNIMPL;
      end else if (illegal_op || creg_spec_undef) begin
        cause = C_ILLEGAL;
      end else if (priv_op && !status_word[`IETU_SR_S]) begin
        cause = C_PRIV;
      end
    end else if (done_eff && forced_exc) begin
      stack_pc = instr_next_pc;
      fault_ptr_ok = (forced_kind != FK_SWTRAP);
      unique case (forced_kind)
        FK_DIV0: cause = C_DIV0;
        FK_BOUND: cause = C_BOUND;
        FK_COND: cause = C_COND;
        FK_SWTRAP: cause = C_SWTRAP;
      endcase
    end else if (done_eff && traced) begin
      stack_pc = instr_next_pc;
      cause = C_TRACE;
    end
  end

  assign take = ce && (cause != C_NONE);

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (instr_start && !take) begin
          st_nxt = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (bkpt_end) begin
          st_nxt = ST_IDLE;
        end else if (done_eff) begin
          st_nxt = (forced_exc && traced) ? ST_TRACE : ST_IDLE;
        end
      end
      ST_TRACE: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= TM_NONE;
      pc_r <= 32'h0000_0000;
    end else if (ce && instr_start && st_r == ST_IDLE) begin
      mode_r <= ietu_trace_t'({status_word[`IETU_SR_T1], status_word[`IETU_SR_T0]});
      pc_r <= instr_pc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      npc_r <= 32'h0000_0000;
    end else if (ce && done_eff) begin
      npc_r <= instr_next_pc;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_word <= `IETU_SR_RST;
    end else if (take) begin
      status_word <= sr_cur;
      status_word[`IETU_SR_S] <= 1'b1;
      status_word[`IETU_SR_T1] <= 1'b0;
      status_word[`IETU_SR_T0] <= 1'b0;
    end else if (ce && sr_load) begin
      status_word <= sr_load_data;
    end
  end

  // Frame contents registered for the stacking sequencer
  // Copy taken before the mode change
  // Handler fetched from base plus offset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      exc_valid <= 1'b0;
      exc_vector <= 8'h00;
      exc_offset <= 10'h000;
      exc_handler_addr <= 32'h0000_0000;
      exc_stack_pc <= 32'h0000_0000;
      exc_fault_ptr <= 32'h0000_0000;
      exc_fault_ptr_valid <= 1'b0;
      exc_saved_sr <= 16'h0000;
    end else if (ce) begin
      exc_valid <= take;
      if (take) begin
        exc_vector <= vec;
        exc_offset <= off;
        exc_handler_addr <= vbr_r + {22'h000000, off};
        exc_stack_pc <= stack_pc;
        exc_fault_ptr <= pc_r;
        exc_fault_ptr_valid <= fault_ptr_ok;
        exc_saved_sr <= sr_cur;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stop_enter <= 1'b0;
    end else if (ce) begin
      stop_enter <= done_eff && stop_op && !traced && !forced_exc;
    end
  end

  // Interrupt held off while a trace is owed
  // Trace ahead of interrupt
  assign irq_take = irq_pending && (st_r != ST_TRACE) && !(done_eff && traced)
                    && (cause == C_NONE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= 32'h0000_0000;
    end else if (take) begin
      cnt_r <= cnt_r + 32'h0000_0001;
    end
  end

  // Base register is the only writable one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vbr_r <= `IETU_VBR_RST;
    end else if (reg_we && reg_waddr == `IETU_VBR_OFF) begin
      vbr_r <= strb_merge(vbr_r, reg_wdata, reg_wstrb) & 32'hFFFF_FFFC;
    end
  end

  assign reg_werr = (reg_waddr != `IETU_VBR_OFF);

  always_comb begin
    reg_rdata = 32'h0000_0000;
    reg_rerr = 1'b0;
    unique case (reg_raddr)
      `IETU_VBR_OFF: reg_rdata = vbr_r;
      `IETU_SR_OFF: reg_rdata = {16'h0000, status_word};
      `IETU_VEC_OFF: reg_rdata = {14'h0000, exc_offset, exc_vector};
      `IETU_PC_OFF: reg_rdata = exc_stack_pc;
      `IETU_PTR_OFF: reg_rdata = exc_fault_ptr;
      `IETU_CNT_OFF: reg_rdata = cnt_r;
      default: reg_rerr = 1'b1;
    endcase
  end

endmodule

// ---- verif/ietu_core_asserts.sv ----
`timescale 1ns/1ps
module ietu_core_asserts import ietu_pkg::*; (
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Instruction flow
  input logic instr_start,
  input logic [31:0] instr_pc,
  input logic [15:0] opcode,
  input logic illegal_op,
  input logic creg_spec_undef,
  input logic priv_op,
  input logic instr_done,
  input logic instr_suspend,
  input logic [31:0] instr_next_pc,
  input logic cof_op,
  input logic stop_op,
  input logic forced_exc,
  input ietu_forced_t forced_kind,
  input logic [3:0] trap_num,
  input logic sr_load,
  input logic bkpt_cycle,
  input logic transfer_ack_n,
  input logic transfer_error_ack_n,
  // Results
  input logic irq_take,
  input logic exc_valid,
  input logic [7:0] exc_vector,
  input logic [9:0] exc_offset,
  input logic [31:0] exc_stack_pc,
  input logic exc_fault_ptr_valid,
  input logic [15:0] exc_saved_sr,
  input logic [15:0] status_word,
  input logic stop_enter
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Starts are only issued to an idle unit
  sequence done_s;
    instr_done && !instr_suspend;
  endsequence
  sequence traced_s;
    done_s ##0 (status_word[15:14] == 2'h2 || (status_word[15:14] == 2'h1 && cof_op));
  endsequence
  sequence exc_s(logic [7:0] v);
    exc_valid && exc_vector == v;
  endsequence

  unimpl_vec_a: assert property (
    instr_start && opcode[15:12] == 4'hA |=> exc_s(8'h0A) ##0 exc_stack_pc == $past(instr_pc))
    else $error("unimplemented opcode exception wrong");
  illegal_vec_a: assert property (
    instr_start && opcode[15:12] != 4'hA && (illegal_op || creg_spec_undef)
    |=> exc_s(8'h04) ##0 exc_stack_pc == $past(instr_pc))
    else $error("illegal opcode exception wrong");
  priv_vec_a: assert property (
    instr_start && priv_op && !status_word[13] && opcode[15:12] != 4'hA && !illegal_op
    && !creg_spec_undef |=> exc_s(8'h08) ##0 exc_stack_pc == $past(instr_pc))
    else $error("privilege violation wrong");
  offset_map_a: assert property (exc_valid |-> exc_offset == {exc_vector, 2'h0})
    else $error("vector offset wrong");
  super_entry_a: assert property (exc_valid |-> status_word[15:13] == 3'h1)
    else $error("status word not supervisor untraced");
  saved_copy_a: assert property (
    $rose(exc_valid) && !$past(sr_load) |-> exc_saved_sr == $past(status_word))
    else $error("saved status copy wrong");
  forced_vec_a: assert property (
    done_s ##0 forced_exc |=> exc_valid && exc_stack_pc == $past(instr_next_pc)
    && exc_fault_ptr_valid == ($past(forced_kind) != FK_SWTRAP)
    && exc_vector == (($past(forced_kind) == FK_SWTRAP) ? 8'h20 + {4'h0, $past(trap_num)}
    : 8'h05 + {6'h0, $past(forced_kind)}))
    else $error("forced trap wrong");
  trace_after_a: assert property (
    traced_s ##0 forced_exc |=> exc_valid ##1 exc_s(8'h09))
    else $error("trace not after forced trap");
  trace_next_a: assert property (
    traced_s ##0 !forced_exc |=> exc_s(8'h09) ##0 (exc_stack_pc == $past(instr_next_pc)
    && !stop_enter))
    else $error("trace exception wrong");
  untraced_quiet_a: assert property (
    done_s ##0 (!forced_exc && !stop_op && (status_word[15:14] == 2'h0
    || status_word[15:14] == 2'h3 || (status_word[15:14] == 2'h1 && !cof_op))) |=> !exc_valid)
    else $error("untraced instruction trapped");
  suspend_hold_a: assert property (instr_done && instr_suspend |=> !exc_valid)
    else $error("suspended instruction trapped");
  trace_irq_a: assert property (traced_s |-> !irq_take)
    else $error("interrupt ahead of trace");
  bkpt_illegal_a: assert property (
    bkpt_cycle && !(transfer_ack_n && transfer_error_ack_n) |=> exc_s(8'h04))
    else $error("breakpoint end not illegal");
endmodule

bind ietu_core ietu_core_asserts i_ietu_core_asserts (.*);

// ---- verif/test_instruction_exception_trace_unit.sv ----
`timescale 1ns/1ps
module test_instruction_exception_trace_unit import ietu_pkg::*;;
  logic aclk = 1'h0;
  logic aresetn, ce;
  logic [7:0] s_axi_awaddr, s_axi_araddr, exc_vector;
  logic [31:0] s_axi_wdata, s_axi_rdata, instr_pc, instr_next_pc;
  logic [31:0] exc_handler_addr, exc_stack_pc, exc_fault_ptr;
  logic [3:0] s_axi_wstrb, trap_num;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic instr_start, illegal_op, creg_spec_undef, priv_op, instr_done, instr_suspend, cof_op;
  logic stop_op, forced_exc, sr_load, bkpt_cycle, transfer_ack_n, transfer_error_ack_n;
  logic irq_pending, irq_take, exc_valid, exc_fault_ptr_valid, stop_enter;
  logic [15:0] opcode, sr_load_data, exc_saved_sr, status_word;
  logic [9:0] exc_offset;
  ietu_forced_t forced_kind;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  int stop_cnt = 0;
  logic [31:0] vbr = 32'h0;
  logic [31:0] cur_pc = 32'h0;
  logic [7:0] vec_tab [4] = '{8'h05, 8'h06, 8'h07, 8'h23};

  ietu_core i_ietu_core (.*);

  always #2 aclk = ~aclk;

  // Hang guard, well past the roughly 120 cycles needed
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      finish_test();
    end
  end

  // Sampled mid-cycle, clear of the edge that launches the pulse
  always @(negedge aclk) begin
    if (stop_enter === 1'h1) begin
      stop_cnt++;
    end
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    b_hs = 1'h0;
    // Handshakes judged mid-cycle, acted on right after the edge
    while (!b_hs) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'h0;
      if (w_hs) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    #1;
    check("bvalid", s_axi_bvalid, 1'h0);
    check("bresp", rsp, r);
  endtask

  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar_hs, r_hs;
    logic [31:0] rd;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    r_hs = 1'h0;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    #1;
    check("rvalid", s_axi_rvalid, 1'h0);
    check("rdata", rd, d);
    check("rresp", rsp, r);
  endtask

  task automatic start_op(input logic [31:0] pc, input logic [15:0] op, input logic il,
                          input logic un, input logic pv);
    @(posedge aclk);
    instr_start <= 1'h1;
    instr_pc <= pc;
    opcode <= op;
    illegal_op <= il;
    creg_spec_undef <= un;
    priv_op <= pv;
    cur_pc = pc;
  endtask

  task automatic done_op(input logic cf, input logic sp, input logic fx, input ietu_forced_t k);
    @(posedge aclk);
    instr_start <= 1'h0;
    instr_done <= 1'h1;
    instr_next_pc <= cur_pc + 32'h4;
    cof_op <= cf;
    stop_op <= sp;
    forced_exc <= fx;
    forced_kind <= k;
    trap_num <= cur_pc[7:4];
  endtask

  task automatic set_sr(input logic [15:0] v);
    @(posedge aclk);
    sr_load <= 1'h1;
    sr_load_data <= v;
    @(posedge aclk);
    sr_load <= 1'h0;
    #1;
    check("status_word", status_word, v);
  endtask

  // Vector zero means no exception within four cycles
  task automatic expect_exc(input logic [7:0] vec, input logic [31:0] spc, input logic fpv);
    int i;
    logic hit;
    hit = 1'h0;
    for (i = 0; i < 4 && !hit; i++) begin
      @(posedge aclk);
      instr_start <= 1'h0;
      instr_done <= 1'h0;
      bkpt_cycle <= 1'h0;
      transfer_ack_n <= 1'h1;
      transfer_error_ack_n <= 1'h1;
      #1;
      hit = (exc_valid === 1'h1);
    end
    check("exc_valid", hit, vec != 8'h00);
    if (hit) begin
      check("exc_vector", exc_vector, vec);
      check("exc_offset", exc_offset, {vec, 2'h0});
      check("exc_handler_addr", exc_handler_addr, vbr + {vec, 2'h0});
      check("exc_stack_pc", exc_stack_pc, spc);
      check("status_word", status_word[15:13], 3'h1);
      if (fpv !== 1'hx) check("exc_fault_ptr_valid", exc_fault_ptr_valid, fpv);
      if (fpv === 1'h1) check("exc_fault_ptr", exc_fault_ptr, cur_pc);
    end
  endtask

  initial begin
    int k;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, instr_pc, instr_next_pc, trap_num} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, aresetn} = '0;
    {instr_start, illegal_op, creg_spec_undef, priv_op, instr_done, instr_suspend} = '0;
    {cof_op, stop_op, forced_exc, sr_load, bkpt_cycle, irq_pending, opcode, sr_load_data} = '0;
    {s_axi_wstrb, transfer_ack_n, transfer_error_ack_n, ce} = '1;
    forced_kind = FK_DIV0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    #1;
    check("status_word", status_word, 16'h2700);
    axi_write(8'h00, 32'h0000_1003, 2'h0);
    axi_read(8'h00, 32'h0000_1000, 2'h0);
    vbr = 32'h0000_1000;
    axi_write(8'h04, 32'hFFFF_FFFF, 2'h2);
    axi_read(8'h18, 32'h0, 2'h2);
    start_op(32'h100, 16'hA123, 1'h1, 1'h0, 1'h0);
    expect_exc(8'h0A, 32'h100, 1'hx);
    start_op(32'h200, 16'h4AFC, 1'h1, 1'h0, 1'h0);
    expect_exc(8'h04, 32'h200, 1'hx);
    start_op(32'h204, 16'h4E7B, 1'h0, 1'h1, 1'h0);
    expect_exc(8'h04, 32'h204, 1'hx);
    axi_read(8'h08, 32'h0000_1004, 2'h0);
    axi_read(8'h14, 32'h3, 2'h0);
    set_sr(16'h0000);
    start_op(32'h300, 16'h46C0, 1'h0, 1'h0, 1'h1);
    expect_exc(8'h08, 32'h300, 1'hx);
    start_op(32'h304, 16'h46C0, 1'h0, 1'h0, 1'h1);
    done_op(1'h0, 1'h0, 1'h0, FK_DIV0);
    expect_exc(8'h00, 32'h0, 1'hx);
    for (k = 0; k < 4; k++) begin
      start_op(32'h400 + 32'(k * 16), 16'h4E40, 1'h0, 1'h0, 1'h0);
      done_op(1'h0, 1'h0, 1'h1, ietu_forced_t'(k[1:0]));
      expect_exc(vec_tab[k], cur_pc + 32'h4, k != 3);
    end
    for (k = 0; k < 2; k++) begin
      @(posedge aclk);
      bkpt_cycle <= 1'h1;
      transfer_ack_n <= k[0];
      transfer_error_ack_n <= !k[0];
      expect_exc(8'h04, cur_pc, 1'hx);
    end
    // Traced divide with an interrupt waiting behind it
    set_sr(16'h8000);
    irq_pending <= 1'h1;
    start_op(32'h500, 16'h80C0, 1'h0, 1'h0, 1'h0);
    done_op(1'h0, 1'h0, 1'h1, FK_DIV0);
    expect_exc(8'h05, 32'h504, 1'h1);
    check("irq_take", irq_take, 1'h0);
    check("exc_saved_sr", exc_saved_sr, 16'h8000);
    expect_exc(8'h09, 32'h504, 1'hx);
    check("irq_take", irq_take, 1'h1);
    check("exc_saved_sr", exc_saved_sr, 16'h2000);
    irq_pending <= 1'h0;
    set_sr(16'h4000);
    start_op(32'h600, 16'h4E71, 1'h0, 1'h0, 1'h0);
    done_op(1'h0, 1'h0, 1'h0, FK_DIV0);
    expect_exc(8'h00, 32'h0, 1'hx);
    start_op(32'h604, 16'h6000, 1'h0, 1'h0, 1'h0);
    done_op(1'h1, 1'h0, 1'h0, FK_DIV0);
    expect_exc(8'h09, 32'h608, 1'hx);
    set_sr(16'hC000);
    start_op(32'h700, 16'h6000, 1'h0, 1'h0, 1'h0);
    done_op(1'h1, 1'h0, 1'h0, FK_DIV0);
    expect_exc(8'h00, 32'h0, 1'hx);
    set_sr(16'h8000);
    start_op(32'h800, 16'h4AFC, 1'h1, 1'h0, 1'h0);
    expect_exc(8'h04, 32'h800, 1'hx);
    expect_exc(8'h00, 32'h0, 1'hx);
    set_sr(16'h8000);
    start_op(32'h900, 16'h2010, 1'h0, 1'h0, 1'h0);
    instr_suspend <= 1'h1;
    done_op(1'h0, 1'h0, 1'h0, FK_DIV0);
    expect_exc(8'h00, 32'h0, 1'hx);
    done_op(1'h0, 1'h0, 1'h0, FK_DIV0);
    instr_suspend <= 1'h0;
    expect_exc(8'h09, 32'h904, 1'hx);
    set_sr(16'h8000);
    start_op(32'hA00, 16'h4E72, 1'h0, 1'h0, 1'h0);
    done_op(1'h1, 1'h1, 1'h0, FK_DIV0);
    expect_exc(8'h09, 32'hA04, 1'hx);
    check("stop_cnt", stop_cnt, 32'h0);
    start_op(32'hA04, 16'h4E72, 1'h0, 1'h0, 1'h0);
    done_op(1'h1, 1'h1, 1'h0, FK_DIV0);
    expect_exc(8'h00, 32'h0, 1'hx);
    check("stop_cnt", stop_cnt, 32'h1);
    finish_test();
  end
endmodule
